// ### slsb_pkg.sv
// constants shared by the serial lane status bank
package slsb_pkg;
  localparam int LANES = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;
  localparam logic [11:0] TABLE_MISS_ERROR_STATUS_ADDR = 12'h46e;
  localparam logic [11:0] UNEXPECTED_CONTROL_CHAR_STATUS_ADDR = 12'h46f;
  localparam logic [11:0] CODE_GROUP_LOCK_STATUS_ADDR = 12'h470;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ONE = 8'h01;
endpackage : slsb_pkg

// ### slsb_err_counter.sv
// saturating per-lane error counter
module slsb_err_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic evt,
  output logic [7:0] count
);
  typedef struct packed {
    logic [7:0] cnt;
  } slsb_cnt_state_t;

  slsb_cnt_state_t state;
  slsb_cnt_state_t next_state;

  always_comb begin
    next_state = state;
    if (clear) begin
      // an error in the clearing cycle is still counted
      next_state.cnt = evt ? slsb_pkg::CNT_ONE : slsb_pkg::CNT_RESET;
    end else if (evt && state.cnt != slsb_pkg::CNT_MAX) begin
      next_state.cnt = 8'(state.cnt + slsb_pkg::CNT_ONE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state.cnt <= slsb_pkg::CNT_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign count = state.cnt;
endmodule : slsb_err_counter

// ### slsb_status_bank.sv
// per-lane error and code group lock status bank
// Summary of operation
// R1: table-miss flag set when count reaches threshold
// R2: control char status at 0x46F, count versus threshold
// R3: lock status at 0x470, 1 achieved
// R4: status bits read-only, reset zero, writes ignored
// R5: lane n reported on bit n
// R6: table-miss status register at 0x46E
// R7: lock bits for lanes 7..0 same encoding
// R8: separate counter per lane, compared every cycle; here counters and flags update only on edges with ce high
module slsb_status_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] table_miss_evt,
  input wire logic [7:0] bad_ctrl_evt,
  input wire logic [7:0] code_lock,
  input wire logic [7:0] error_count_threshold,
  input wire logic err_count_clear,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic [7:0] table_miss_error_status,
  output logic [7:0] unexpected_control_char_status,
  output logic [7:0] code_group_lock_status
);
  typedef struct packed {
    logic [7:0] table_miss;
    logic [7:0] bad_ctrl;
    logic [7:0] code_lock;
    logic [7:0] rdata;
  } slsb_state_t;

  // register picked by a read
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_MISS = 2'b01,
    SEL_CTRL = 2'b10,
    SEL_LOCK = 2'b11
  } slsb_rd_sel_t;

  slsb_state_t state;
  slsb_state_t next_state;
  slsb_rd_sel_t rd_sel;
  logic [7:0] miss_cnt [slsb_pkg::LANES];
  logic [7:0] ctrl_cnt [slsb_pkg::LANES];

  // named flags, one per lane and kind
  logic lane0_table_miss_flag;
  logic lane1_table_miss_flag;
  logic lane2_table_miss_flag;
  logic lane3_table_miss_flag;
  logic lane4_table_miss_flag;
  logic lane5_table_miss_flag;
  logic lane6_table_miss_flag;
  logic lane7_table_miss_flag;

  logic lane0_bad_control_char_flag;
  logic lane1_bad_control_char_flag;
  logic lane2_bad_control_char_flag;
  logic lane3_bad_control_char_flag;
  logic lane4_bad_control_char_flag;
  logic lane5_bad_control_char_flag;
  logic lane6_bad_control_char_flag;
  logic lane7_bad_control_char_flag;

  logic lane0_code_lock_flag;
  logic lane1_code_lock_flag;
  logic lane2_code_lock_flag;
  logic lane3_code_lock_flag;
  logic lane4_code_lock_flag;
  logic lane5_code_lock_flag;
  logic lane6_code_lock_flag;
  logic lane7_code_lock_flag;

  // count at or above threshold raises the flag
  function automatic logic at_threshold(
    input logic [7:0] cnt,
    input logic [7:0] thr
  );
    at_threshold = (cnt >= thr); // R1 R2
  endfunction : at_threshold

  // address decode for the read mux
  function automatic slsb_rd_sel_t decode_addr(input logic [11:0] addr);
    if (addr == slsb_pkg::TABLE_MISS_ERROR_STATUS_ADDR) begin
      decode_addr = SEL_MISS; // R6
    end else if (addr == slsb_pkg::UNEXPECTED_CONTROL_CHAR_STATUS_ADDR) begin
      decode_addr = SEL_CTRL; // R2
    end else if (addr == slsb_pkg::CODE_GROUP_LOCK_STATUS_ADDR) begin
      decode_addr = SEL_LOCK; // R3
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction : decode_addr

  // one counter per lane and per error kind
  for (genvar g = 0; g < slsb_pkg::LANES; g++) begin : g_lane
    slsb_err_counter u_miss (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .clear(err_count_clear),
      .evt(table_miss_evt[g]),
      .count(miss_cnt[g])
    ); // R8
    slsb_err_counter u_ctrl (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .clear(err_count_clear),
      .evt(bad_ctrl_evt[g]),
      .count(ctrl_cnt[g])
    ); // R8
  end

  always_comb begin
    next_state = state;
    rd_sel = decode_addr(cfg_addr);
    // flags trail their counters by one enabled edge
    for (int i = 0; i < slsb_pkg::LANES; i++) begin
      next_state.table_miss[i] = at_threshold(miss_cnt[i], error_count_threshold); // R1
      next_state.bad_ctrl[i] = at_threshold(ctrl_cnt[i], error_count_threshold); // R2
    end
    // lock level passes through, one edge late
    next_state.code_lock = code_lock; // R3
    // writes have no path into the status bits
    // last read value stands until the next read
    if (cfg_rd) begin
      case (rd_sel)
        SEL_MISS: begin
          next_state.rdata = state.table_miss; // R6
        end
        SEL_CTRL: begin
          next_state.rdata = state.bad_ctrl; // R2
        end
        SEL_LOCK: begin
          next_state.rdata = state.code_lock; // R3 R7
        end
        default: begin
          // unmapped addresses read as zero
          next_state.rdata = slsb_pkg::UNMAPPED_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    // reset wins over a low clock enable
    if (rst) begin
      state.table_miss <= slsb_pkg::STATUS_RESET; // R4
      state.bad_ctrl <= slsb_pkg::STATUS_RESET; // R4
      state.code_lock <= slsb_pkg::STATUS_RESET; // R4
      state.rdata <= slsb_pkg::RDATA_RESET;
    end else if (ce) begin
      // low enable freezes flags and read data
      state <= next_state;
    end
  end

  // bit n of each register is lane n
  assign lane0_table_miss_flag = state.table_miss[0];
  assign lane1_table_miss_flag = state.table_miss[1];
  assign lane2_table_miss_flag = state.table_miss[2];
  assign lane3_table_miss_flag = state.table_miss[3];
  assign lane4_table_miss_flag = state.table_miss[4];
  assign lane5_table_miss_flag = state.table_miss[5];
  assign lane6_table_miss_flag = state.table_miss[6];
  assign lane7_table_miss_flag = state.table_miss[7];

  assign lane0_bad_control_char_flag = state.bad_ctrl[0];
  assign lane1_bad_control_char_flag = state.bad_ctrl[1];
  assign lane2_bad_control_char_flag = state.bad_ctrl[2];
  assign lane3_bad_control_char_flag = state.bad_ctrl[3];
  assign lane4_bad_control_char_flag = state.bad_ctrl[4];
  assign lane5_bad_control_char_flag = state.bad_ctrl[5];
  assign lane6_bad_control_char_flag = state.bad_ctrl[6];
  assign lane7_bad_control_char_flag = state.bad_ctrl[7];

  assign lane0_code_lock_flag = state.code_lock[0];
  assign lane1_code_lock_flag = state.code_lock[1];
  assign lane2_code_lock_flag = state.code_lock[2];
  assign lane3_code_lock_flag = state.code_lock[3];
  assign lane4_code_lock_flag = state.code_lock[4];
  assign lane5_code_lock_flag = state.code_lock[5];
  assign lane6_code_lock_flag = state.code_lock[6];
  assign lane7_code_lock_flag = state.code_lock[7];

  assign table_miss_error_status = {
    lane7_table_miss_flag,
    lane6_table_miss_flag,
    lane5_table_miss_flag,
    lane4_table_miss_flag,
    lane3_table_miss_flag,
    lane2_table_miss_flag,
    lane1_table_miss_flag,
    lane0_table_miss_flag
  }; // R5

  assign unexpected_control_char_status = {
    lane7_bad_control_char_flag,
    lane6_bad_control_char_flag,
    lane5_bad_control_char_flag,
    lane4_bad_control_char_flag,
    lane3_bad_control_char_flag,
    lane2_bad_control_char_flag,
    lane1_bad_control_char_flag,
    lane0_bad_control_char_flag
  }; // R5

  assign code_group_lock_status = {
    lane7_code_lock_flag,
    lane6_code_lock_flag,
    lane5_code_lock_flag,
    lane4_code_lock_flag,
    lane3_code_lock_flag,
    lane2_code_lock_flag,
    lane1_code_lock_flag,
    lane0_code_lock_flag
  }; // R5 R7

  assign cfg_rdata = state.rdata;
endmodule : slsb_status_bank

// ### slsb_props.sv
// concurrent checks on the status bank ports
module slsb_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] code_lock,
  input wire logic [7:0] cfg_rdata,
  input wire logic [7:0] table_miss_error_status,
  input wire logic [7:0] unexpected_control_char_status,
  input wire logic [7:0] code_group_lock_status
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rd = ce && cfg_rd;
  wire logic [11:0] ad = cfg_addr;
  wire logic [7:0] rv = cfg_rdata, tm = table_miss_error_status;
  wire logic [7:0] uc = unexpected_control_char_status, cg = code_group_lock_status;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  lock_follow_a: assert property (ce |=> cg == $past(code_lock)) else $error("lock");
  rd_lock_a: assert property (rd && ad == 12'h470 |=> rv == $past(cg)) else $error("rd");
  rd_miss_a: assert property (rd && ad == 12'h46e |=> rv == $past(tm)) else $error("rd");
  rd_ctrl_a: assert property (rd && ad == 12'h46f |=> rv == $past(uc)) else $error("rd");
  rd_none_a: assert property (rd && ad == 12'h471 |=> rv == 8'h00) else $error("rd");
  rst_zero_a: assert property (disable iff (1'b0) rst |=> (tm | uc | cg | rv) == 8'h00)
    else $error("reset");
  ce_hold_a: assert property (!ce |=> $stable({tm, uc, cg})) else $error("held");
  rd_hold_a: assert property (!rd |=> $stable(rv)) else $error("rdata moved");
  lock_read_c: cover property (rd && ad == 12'h470);
  flag_set_c: cover property (tm != 8'h00 && uc != 8'h00);
  ce_low_c: cover property (!ce ##1 !ce);
  miss_clear_c: cover property (tm != 8'h00 ##1 tm == 8'h00);
endmodule : slsb_props

// ### slsb_lane_tx.sv
// lane transmitter model: bits 7:0 table miss, 15:8 bad control char, 23:16 lock
module slsb_lane_tx (
  input wire logic clk,
  input wire logic [23:0] req,
  output logic [23:0] lane = 24'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) lane <= #1 req;
endmodule : slsb_lane_tx

// ### slsb_status_bank_tb.sv
// bench for the serial lane status bank
module slsb_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, ce = 1, rd = 0, wr = 0;
  logic [7:0] rdata, tms, ucs, cgs;
  logic [11:0] addr = 12'h000;
  logic [23:0] req = 24'h0, lane;
  logic [7:0] thr = 8'h03;
  logic clr = 1'h0;
  int err_count = 0, total_checks = 0;
  logic [43:0] rows [6] = '{{24'h010004, 12'h46e, 8'h00}, {24'h012004, 12'h46f, 8'h00},
    {24'h802004, 12'h46e, 8'h04}, {24'h802000, 12'h46f, 8'h20},
    {24'ha50000, 12'h470, 8'ha5}, {24'ha50000, 12'h471, 8'h00}};
  always #5 clk = ~clk;
  slsb_lane_tx slsb_lane_tx_i (.clk(clk), .req(req), .lane(lane));
  slsb_status_bank slsb_status_bank_i (.clk(clk), .rst(rst), .ce(ce), .cfg_wdata(8'hff),
    .table_miss_evt(lane[7:0]), .bad_ctrl_evt(lane[15:8]), .code_lock(lane[23:16]),
    .error_count_threshold(thr), .err_count_clear(clr), .cfg_addr(addr), .cfg_rd(rd),
    .cfg_wr(wr), .cfg_rdata(rdata), .table_miss_error_status(tms),
    .unexpected_control_char_status(ucs), .code_group_lock_status(cgs));
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    if (got !== exp) err_count++;
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    cyc(3);
    rst = 0;
    // each row: one error pulse per set bit of 15:0, lock bits held, a write that must be ignored, then a read
    foreach (rows[i]) begin
      {req, addr} = rows[i][43:8];
      wr = 1;
      cyc(1);
      req[15:0] = 16'h0;
      wr = 0;
      cyc(3);
      rd = 1;
      cyc(1);
      rd = 0;
      chk(rdata, rows[i][7:0]);
      $display("row %0d done", i);
    end
    // threshold above the counts drops the flags, back at the counts raises them
    thr = 8'h04;
    cyc(1);
    chk(tms, 8'h00);
    chk(ucs, 8'h00);
    thr = 8'h03;
    cyc(1);
    chk(tms, 8'h04);
    chk(ucs, 8'h20);
    // clear empties the counters, zero threshold then sets every table-miss and control-char flag
    clr = 1'h1;
    cyc(1);
    clr = 1'h0;
    cyc(1);
    chk(tms | ucs, 8'h00);
    thr = 8'h00;
    cyc(1);
    chk(tms & ucs, 8'hff);
    $display("threshold and clear done");
    thr = 8'h03;
    ce = 0;
    req[23:16] = 8'h3c;
    cyc(3);
    chk(cgs, 8'ha5);
    chk(tms, 8'hff);
    // reset must act with the clock enable low
    rst = 1;
    cyc(1);
    rst = 0;
    ce = 1;
    chk(tms | ucs | cgs, 8'h00);
    $display("freeze and reset done");
    summarize();
  end
endmodule : slsb_status_bank_tb
bind slsb_status_bank slsb_props slsb_props_i (.clk(clk), .rst(rst), .ce(ce), .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr), .code_lock(code_lock), .cfg_rdata(cfg_rdata),
  .table_miss_error_status(table_miss_error_status),
  .unexpected_control_char_status(unexpected_control_char_status),
  .code_group_lock_status(code_group_lock_status));
